/* File: verilog/audio_timing_pkg.sv */
// Purpose: Shared constants for the embedded audio and timing generator.
// Assumes: 200 MHz system clock; registers reached over a plain port.
// Notes: Register offsets are word indices on the plain port.
package audio_timing_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned NGRP = 4;
    localparam int unsigned NCH = 4;
    localparam int unsigned NFREQ = 34;
    localparam logic [5:0] FREQ_INACTIVE = 6'h00;
    localparam logic [5:0] FREQ_SILENCE = 6'h01;
    localparam logic [5:0] FREQ_DEF = 6'h15;
    localparam logic [5:0] AMP_DEF = 6'h14;
    localparam logic [5:0] AMP_MAX = 6'h3C;
    localparam logic [2:0] CLICK_MAX = 3'h4;
    localparam logic [1:0] EMPH_MAX = 2'h2;
    localparam logic [1:0] ALIGN_MAX = 2'h2;
    localparam logic [1:0] TC_OFF = 2'h0;
    localparam logic [1:0] TC_TOD = 2'h1;
    localparam logic [1:0] TC_PROG = 2'h2;
    localparam int unsigned CLICK_GAP_MS = 250;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned SAMPLE_RATE_HZ = 48000;
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int unsigned CLICK_GAP_SAMPLES =
        SAMPLE_RATE_HZ * CLICK_GAP_MS / MS_PER_S;
    localparam logic [11:0] H_LIMIT = 12'hFFF;
    localparam logic [10:0] V_LIMIT = 11'h7FF;
    localparam logic [4:0] TC_HOUR_MAX = 5'h17;
    localparam logic [5:0] TC_MIN_MAX = 6'h3B;
    localparam logic [5:0] TC_SEC_MAX = 6'h3B;
    localparam logic [4:0] TC_FRM_MAX = 5'h1D;
    localparam logic [7:0] A_COMMIT = 8'h00;
    localparam logic [7:0] A_GRP0 = 8'h01;
    localparam logic [7:0] A_CH0 = 8'h08;
    localparam logic [7:0] A_VOFF = 8'h20;
    localparam logic [7:0] A_HOFF = 8'h21;
    localparam logic [7:0] A_TCSRC = 8'h22;
    localparam logic [7:0] A_TCOFF = 8'h23;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [23:0] FULL_SCALE = 24'h7FFFFF;
    localparam logic [23:0] CLICK_VAL = 24'h7FFFFF;
endpackage

/* File: verilog/embedded_audio_timing_gen.sv */
// Behaviour
// RQ1: Each audio group has an enable; audio only flows while enabled.
// RQ2: Four groups of four channels, each with tone, level and click.
// RQ3: Group emphasis status is none, CD or CCITT.
// RQ4: Group alignment status is frame, frame without number, or async.
// RQ5: Group samples are produced at 24 or 20 bit resolution.
// RQ6: Each channel plays a tone from a fixed list, or silence.
// RQ7: An inactive channel emits no samples at all.
// RQ8: Tone level from -60 to 0 dBFS in 1 dB steps; the output applies it only in 6 dB shifts.
// RQ9: Click period of 1, 2, 3 or 4 seconds, or off.
// RQ10: With clicks on, tone is muted a quarter second; click inside it.
// RQ11: With clicks off the tone plays continuously.
// RQ12: Vertical offset spans half a frame either way, in lines.
// RQ13: Horizontal offset spans one line either way, in sample clocks.
// RQ14: Timecode source is time of day, program time, or off.
// RQ15: A signed offset up to 23:59:59:29 is added to the timecode.
// RQ16: Software keeps zone plus daylight offset within -12 to +13 hours.
// RQ17: Committed settings take effect only at the next frame boundary.
// Purpose: Settings store and sample generator for embedded test audio.
// Assumes: Frame pulse and timecode inputs are on clk_sys_i.
// Notes: Tones come from a phase accumulator with a square wave.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module embedded_audio_timing_gen
    import audio_timing_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Frame reference and timecode sources.
    input wire logic frame_i,
    input wire logic [22:0] tod_i,
    input wire logic [22:0] prog_i,
    // Audio sample stream.
    output logic smp_valid_o,
    input wire logic smp_ready_i,
    output logic [23:0] smp_data_o,
    output logic [3:0] smp_chan_o,
    output logic [1:0] smp_emph_o,
    output logic [1:0] smp_align_o,
    // Timing and timecode outputs.
    output logic signed [10:0] voff_o,
    output logic signed [12:0] hoff_o,
    output logic tc_valid_o,
    output logic [22:0] tc_o
);
    localparam int unsigned NALL = NGRP * NCH;

    // Step per sample for each list frequency, scaled to 2^32 / 48 kHz.
    function automatic logic [31:0] freq_step(input logic [5:0] sel);
        logic [31:0] hz;
        hz = 32'h0;
        case (sel)
            6'h02: hz = 32'd50;    6'h03: hz = 32'd100;
            6'h04: hz = 32'd150;   6'h05: hz = 32'd200;
            6'h06: hz = 32'd250;   6'h07: hz = 32'd300;
            6'h08: hz = 32'd400;   6'h09: hz = 32'd500;
            6'h0A: hz = 32'd600;   6'h0B: hz = 32'd750;
            6'h0C: hz = 32'd800;   6'h0D: hz = 32'd1000;
            6'h0E: hz = 32'd1200;  6'h0F: hz = 32'd1500;
            6'h10: hz = 32'd1600;  6'h11: hz = 32'd2000;
            6'h12: hz = 32'd2400;  6'h13: hz = 32'd3000;
            6'h14: hz = 32'd3200;  6'h15: hz = 32'd4000;
            6'h16: hz = 32'd4800;  6'h17: hz = 32'd5000;
            6'h18: hz = 32'd6000;  6'h19: hz = 32'd8000;
            6'h1A: hz = 32'd9600;  6'h1B: hz = 32'd10000;
            6'h1C: hz = 32'd12000; 6'h1D: hz = 32'd15000;
            6'h1E: hz = 32'd16000; 6'h1F: hz = 32'd20000;
            default: hz = 32'h0;
        endcase
        freq_step = 32'(({32'h0, hz} << 32) / SAMPLE_RATE_HZ);
    endfunction

    // Level as a right shift: about 6 dB per bit, coarse but monotone.
    function automatic logic [23:0] scale(input logic [23:0] v,
                                          input logic [5:0] db);
        scale = v >> (db / 6);
    endfunction

    // Shadow (written) and live (in force) settings.
    logic [NGRP-1:0] g_en_s, g_en_r;
    logic [1:0] g_emph_s [NGRP], g_emph_r [NGRP];
    logic [1:0] g_align_s [NGRP], g_align_r [NGRP];
    logic [NGRP-1:0] g_res20_s, g_res20_r;
    logic [5:0] c_freq_s [NALL], c_freq_r [NALL];
    logic [5:0] c_att_s [NALL], c_att_r [NALL];
    logic [2:0] c_click_s [NALL], c_click_r [NALL];
    logic signed [10:0] voff_s;
    logic signed [12:0] hoff_s;
    logic [1:0] tcsrc_s, tcsrc_r;
    logic [23:0] tcoff_s, tcoff_r;
    logic pend_r;

    wire sel_grp = wr_i && addr_i >= A_GRP0 && addr_i < A_GRP0 + 8'(NGRP);
    wire sel_ch = wr_i && addr_i >= A_CH0 && addr_i < A_CH0 + 8'(NALL);
    wire [1:0] gi = 2'(addr_i - A_GRP0);
    wire [3:0] ci = 4'(addr_i - A_CH0);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            g_en_s <= '0;
            g_res20_s <= '0;
            voff_s <= '0;
            hoff_s <= '0;
            tcsrc_s <= TC_OFF;
            tcoff_s <= '0;
            pend_r <= 1'b0;
            for (int i = 0; i < NGRP; i++)
            begin
                g_emph_s[i] <= '0;
                g_align_s[i] <= '0;
            end
            for (int i = 0; i < NALL; i++)
            begin
                c_freq_s[i] <= FREQ_DEF;
                c_att_s[i] <= AMP_DEF;
                c_click_s[i] <= '0;
            end
        end
        else
        begin
            if (sel_grp)
            begin
                g_en_s[gi] <= wdata_i[0]; // RQ1
                if (wdata_i[2:1] <= EMPH_MAX)
                    g_emph_s[gi] <= wdata_i[2:1]; // RQ3
                if (wdata_i[4:3] <= ALIGN_MAX)
                    g_align_s[gi] <= wdata_i[4:3]; // RQ4
                g_res20_s[gi] <= wdata_i[5]; // RQ5
            end
            if (sel_ch)
            begin
                if (wdata_i[5:0] < 6'(NFREQ))
                    c_freq_s[ci] <= wdata_i[5:0]; // RQ6
                if (wdata_i[13:8] <= AMP_MAX)
                    c_att_s[ci] <= wdata_i[13:8]; // RQ8
                if (wdata_i[18:16] <= CLICK_MAX)
                    c_click_s[ci] <= wdata_i[18:16]; // RQ9
            end
            if (wr_i && addr_i == A_VOFF)
                voff_s <= 11'(wdata_i[10:0]); // RQ12
            if (wr_i && addr_i == A_HOFF)
                hoff_s <= 13'(wdata_i[12:0]); // RQ13
            if (wr_i && addr_i == A_TCSRC && wdata_i[1:0] <= TC_PROG)
                tcsrc_s <= wdata_i[1:0]; // RQ14
            if (wr_i && addr_i == A_TCOFF)
                tcoff_s <= wdata_i[23:0]; // RQ15
            // A commit arriving with the frame pulse stays pending.
            if (wr_i && addr_i == A_COMMIT)
                pend_r <= 1'b1;
            else if (frame_i)
                pend_r <= 1'b0;
        end
    end

    // Apply only at a frame pulse so no frame mixes old and new settings.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            g_en_r <= '0;
            g_res20_r <= '0;
            voff_o <= '0;
            hoff_o <= '0;
            tcsrc_r <= TC_OFF;
            tcoff_r <= '0;
            for (int i = 0; i < NGRP; i++)
            begin
                g_emph_r[i] <= '0;
                g_align_r[i] <= '0;
            end
            for (int i = 0; i < NALL; i++)
            begin
                c_freq_r[i] <= FREQ_DEF;
                c_att_r[i] <= AMP_DEF;
                c_click_r[i] <= '0;
            end
        end
        else if (frame_i && pend_r) // RQ17
        begin
            g_en_r <= g_en_s;
            g_res20_r <= g_res20_s;
            voff_o <= voff_s;
            hoff_o <= hoff_s;
            tcsrc_r <= tcsrc_s;
            tcoff_r <= tcoff_s;
            g_emph_r <= g_emph_s;
            g_align_r <= g_align_s;
            c_freq_r <= c_freq_s;
            c_att_r <= c_att_s;
            c_click_r <= c_click_s;
        end
    end

    // Sample tick and per-channel scan.
    logic [15:0] div_r;
    logic [3:0] scan_r;
    logic busy_r;
    logic [31:0] phase_r [NALL];
    logic [17:0] cnt_r [NALL];
    wire tick = div_r == 16'(SAMPLE_DIV - 1);

    wire [1:0] sg = scan_r[3:2];
    wire [2:0] clk_sel = c_click_r[scan_r];
    wire [17:0] click_len = 18'(clk_sel * SAMPLE_RATE_HZ);
    wire in_gap = clk_sel != 3'h0 && cnt_r[scan_r] < 18'(CLICK_GAP_SAMPLES);
    wire click_hit = in_gap && cnt_r[scan_r] == 18'(CLICK_GAP_SAMPLES / 2);
    wire chan_on = g_en_r[sg] && c_freq_r[scan_r] != FREQ_INACTIVE;
    wire [23:0] tone = phase_r[scan_r][31] ? FULL_SCALE : ~FULL_SCALE;
    wire [23:0] raw = (c_freq_r[scan_r] == FREQ_SILENCE || in_gap) // RQ10
                      ? (click_hit ? CLICK_VAL : 24'h0) // RQ10
                      : scale(tone, c_att_r[scan_r]); // RQ11
    wire [23:0] word = g_res20_r[sg] ? {raw[23:4], 4'h0} : raw; // RQ5

    // Two-entry buffer between generator and receiver.
    logic [31:0] buf_r [2];
    logic [1:0] cnt_b;
    logic rp_r, wp_r;
    wire push = busy_r && chan_on && cnt_b != 2'h2; // RQ1 RQ7
    wire stall = busy_r && chan_on && cnt_b == 2'h2;
    wire pop = smp_valid_o && smp_ready_i;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_r <= '0;
            scan_r <= '0;
            busy_r <= 1'b0;
            for (int i = 0; i < NALL; i++)
            begin
                phase_r[i] <= '0;
                cnt_r[i] <= '0;
            end
        end
        else
        begin
            div_r <= tick ? 16'h0 : div_r + 16'h1;
            if (tick)
                busy_r <= 1'b1;
            if (busy_r && !stall)
            begin
                phase_r[scan_r] <= phase_r[scan_r]
                                   + freq_step(c_freq_r[scan_r]); // RQ6
                if (clk_sel == 3'h0 || cnt_r[scan_r] >= click_len - 18'h1)
                    cnt_r[scan_r] <= '0; // RQ9
                else
                    cnt_r[scan_r] <= cnt_r[scan_r] + 18'h1;
                scan_r <= scan_r + 4'h1; // RQ2
                if (scan_r == 4'(NALL - 1))
                    busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_b <= '0;
            rp_r <= 1'b0;
            wp_r <= 1'b0;
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_r[wp_r] <= {g_align_r[sg], g_emph_r[sg],
                                scan_r, word}; // RQ3 RQ4
                wp_r <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            cnt_b <= cnt_b + 2'(push) - 2'(pop);
        end
    end

    assign smp_valid_o = cnt_b != 2'h0;
    assign {smp_align_o, smp_emph_o, smp_chan_o, smp_data_o} = buf_r[rp_r];

    // Timecode: hh:mm:ss:ff packed 5/6/6/5 bits plus a sign bit on the offset.
    function automatic logic [22:0] tc_add(input logic [22:0] a,
                                           input logic [23:0] o);
        logic [6:0] f, s, m, h;
        logic c;
        f = 7'(a[4:0]) + (o[23] ? 7'(TC_FRM_MAX) + 7'h1 - 7'(o[4:0])
                                : 7'(o[4:0]));
        c = f > 7'(TC_FRM_MAX);
        f = c ? f - 7'(TC_FRM_MAX) - 7'h1 : f;
        s = 7'(a[10:5]) + 7'(c) + (o[23] ? 7'(TC_SEC_MAX) - 7'(o[10:5])
                                        : 7'(o[10:5]));
        c = s > 7'(TC_SEC_MAX);
        s = c ? s - 7'(TC_SEC_MAX) - 7'h1 : s;
        m = 7'(a[16:11]) + 7'(c) + (o[23] ? 7'(TC_MIN_MAX) - 7'(o[16:11])
                                         : 7'(o[16:11]));
        c = m > 7'(TC_MIN_MAX);
        m = c ? m - 7'(TC_MIN_MAX) - 7'h1 : m;
        h = 7'(a[21:17]) + 7'(c) + (o[23] ? 7'(TC_HOUR_MAX) - 7'(o[21:17])
                                         : 7'(o[21:17]));
        h = h > 7'(TC_HOUR_MAX) ? h - 7'(TC_HOUR_MAX) - 7'h1 : h;
        tc_add = {1'b0, h[4:0], m[5:0], s[5:0], f[4:0]};
    endfunction

    wire [22:0] tc_src = tcsrc_r == TC_TOD ? tod_i : prog_i; // RQ14
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tc_o <= '0;
            tc_valid_o <= 1'b0;
        end
        else
        begin
            tc_valid_o <= tcsrc_r != TC_OFF; // RQ14
            tc_o <= tcsrc_r == TC_OFF ? 23'h0
                                      : tc_add(tc_src, tcoff_r); // RQ15
        end
    end

    // Read port.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else if (rd_i)
        begin
            rdata_o <= '0;
            if (addr_i == A_STATUS)
                rdata_o <= {28'h0, cnt_b, busy_r, pend_r};
            else if (addr_i == A_VOFF)
                rdata_o <= 32'(voff_s);
            else if (addr_i == A_HOFF)
                rdata_o <= 32'(hoff_s);
            else if (addr_i == A_TCSRC)
                rdata_o <= {30'h0, tcsrc_s};
            else if (addr_i == A_TCOFF)
                rdata_o <= {8'h0, tcoff_s};
            else if (addr_i >= A_GRP0 && addr_i < A_GRP0 + 8'(NGRP))
                rdata_o <= {26'h0, g_res20_s[gi], g_align_s[gi],
                            g_emph_s[gi], g_en_s[gi]};
            else if (addr_i >= A_CH0 && addr_i < A_CH0 + 8'(NALL))
                rdata_o <= {13'h0, c_click_s[ci], 2'h0, c_att_s[ci],
                            2'h0, c_freq_s[ci]};
        end
    end
endmodule
`default_nettype wire

/* File: verification/audio_timing_assertions.sv */
// Purpose: Port checks for the embedded audio and timing generator.
// Assumes: One clock domain, reset active high.
// Notes: Offset moves are tied to the frame pulse one cycle earlier, timecode source moves two cycles earlier.
`timescale 1ns/1ps
`default_nettype none
module audio_timing_assertions
    import audio_timing_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic frame_i,
    // Sample stream.
    input wire logic smp_valid_o,
    input wire logic smp_ready_i,
    input wire logic [23:0] smp_data_o,
    input wire logic [3:0] smp_chan_o,
    input wire logic [1:0] smp_emph_o,
    input wire logic [1:0] smp_align_o,
    // Timing and timecode.
    input wire logic signed [10:0] voff_o,
    input wire logic signed [12:0] hoff_o,
    input wire logic tc_valid_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // A stalled word must not be lost, nor its data or channel altered.
    a_valid_hold: assert property (
        smp_valid_o && !smp_ready_i |=> smp_valid_o)
        else $error("sample withdrawn while stalled");
    a_data_hold: assert property (
        smp_valid_o && !smp_ready_i
        |=> $stable(smp_data_o) && $stable(smp_chan_o))
        else $error("stalled sample changed");
    a_emph_code: assert property (
        smp_valid_o |-> smp_emph_o <= EMPH_MAX)
        else $error("emphasis code out of range");
    a_align_code: assert property (
        smp_valid_o |-> smp_align_o <= ALIGN_MAX)
        else $error("alignment code out of range");
    a_voff_frame: assert property (
        $changed(voff_o) |-> $past(frame_i))
        else $error("vertical offset moved off a frame");
    a_hoff_frame: assert property (
        $changed(hoff_o) |-> $past(frame_i))
        else $error("horizontal offset moved off a frame");
    a_tc_frame: assert property (
        $changed(tc_valid_o) |-> $past(frame_i, 2))
        else $error("timecode source moved off a frame");
    a_quiet_reset: assert property (
        $fell(rst_i) |-> !smp_valid_o && !tc_valid_o)
        else $error("output active after reset");
    a_rdata_hold: assert property (
        !$past(rd_i) |-> $stable(rdata_o))
        else $error("read data moved without a read");
    c_stall: cover property (smp_valid_o && !smp_ready_i);
    c_tc_on: cover property ($rose(tc_valid_o));
    c_voff: cover property (voff_o != 11'sh000);
endmodule
`default_nettype wire

/* File: verification/stream_sink.sv */
// Purpose: Receiver model that takes samples and stalls at will.
// Assumes: Sample stream on the system clock.
// Notes: A long hold lets the buffer fill so its refusal is seen.
`timescale 1ns/1ps
`default_nettype none
module stream_sink
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Control from the bench.
    input wire logic hold_i,
    // Sample stream.
    input wire logic smp_valid_i,
    output logic smp_ready_o
);
    int seed = 12765;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            smp_ready_o <= 1'b0;
        else
            smp_ready_o <= !hold_i && ($random(seed) % 4 != 0);
    end
endmodule
`default_nettype wire

/* File: verification/embedded_audio_timing_gen_tb.sv */
// Purpose: Self-checking bench for the audio and timing generator.
// Assumes: Settings apply on the frame pulse after a commit.
// Notes: Clicks need a quarter second, too long for this run.
`timescale 1ns/1ps
`default_nettype none
module embedded_audio_timing_gen_tb;
    import audio_timing_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic frame_i = 1'b0;
    logic [22:0] tod_i = {1'b0, 5'h0A, 6'h14, 6'h1E, 5'h05};
    logic [22:0] prog_i = {1'b0, 5'h03, 6'h04, 6'h05, 5'h06};
    logic hold = 1'b1;
    logic smp_ready_i, smp_valid_o, tc_valid_o;
    logic [31:0] rdata_o;
    logic [23:0] smp_data_o;
    logic [3:0] smp_chan_o;
    logic [1:0] smp_emph_o, smp_align_o;
    logic signed [10:0] voff_o;
    logic signed [12:0] hoff_o;
    logic [22:0] tc_o;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 12765;
    int audio_on = 0;
    int taken = 0;
    int v;
    int q[$] = '{4, 6};

    embedded_audio_timing_gen i_embedded_audio_timing_gen (.*);
    stream_sink i_stream_sink (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .hold_i(hold), .smp_valid_i(smp_valid_o),
        .smp_ready_o(smp_ready_i));

    always #2.5 clk_sys_i = !clk_sys_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, e);
    endtask

    task automatic frame_pulse();
        @(posedge clk_sys_i);
        frame_i <= 1'b1;
        @(posedge clk_sys_i);
        frame_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic commit();
        wr(A_COMMIT, 32'h0);
        frame_pulse();
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Model of the scan: group two, channels one and three take turns.
    always @(posedge clk_sys_i)
    begin
        if (!rst_i && smp_valid_o === 1'b1 && smp_ready_i === 1'b1)
        begin
            if (taken == 0 && smp_chan_o === 4'h6)
                q.push_back(q.pop_front());
            check(audio_on, 1);
            check(smp_chan_o, q[0]);
            check(smp_emph_o, 1);
            check(smp_align_o, 2);
            check(smp_data_o[3:0], 0);
            check(smp_data_o == 0, q[0] == 4);
            q.push_back(q.pop_front());
            taken++;
        end
    end

    initial
    begin
        repeat (100000) @(posedge clk_sys_i);
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1 check(smp_valid_o, 0);
        check(tc_valid_o, 0);
        rd(8'h30, 32'h0);
        // Emphasis and alignment codes zero to two are kept; code three is refused.
        for (int e = 0; e < 3; e++)
        begin
            wr(A_GRP0, e * 10);
            rd(A_GRP0, e * 10);
        end
        wr(A_GRP0, 32'h1E);
        rd(A_GRP0, 32'h14);
        wr(A_CH0, 32'h00043C21);
        rd(A_CH0, 32'h00043C21);
        wr(A_CH0, 32'h00053D22);
        rd(A_CH0, 32'h00043C21);
        v = $random(seed) % 200;
        wr(A_VOFF, v);
        wr(A_HOFF, -v * 3);
        wr(A_COMMIT, 32'h0);
        repeat (4) @(posedge clk_sys_i);
        check(voff_o, 0);
        frame_pulse();
        check(voff_o, v);
        check(hoff_o, -v * 3);
        for (int s = 1; s < 3; s++)
        begin
            wr(A_TCSRC, s);
            commit();
            check(tc_valid_o, 1);
            check(tc_o, s == 1 ? tod_i : prog_i);
        end
        // Offsets stay small, well inside the zone range software keeps.
        wr(A_TCOFF, 32'h1);
        wr(A_TCSRC, 32'h1);
        commit();
        check(tc_o, tod_i + 1);
        wr(A_TCOFF, 32'h800001);
        commit();
        check(tc_o, tod_i - 1);
        wr(A_TCSRC, 32'h0);
        commit();
        check(tc_valid_o, 0);
        wr(A_TCSRC, 32'h3);
        rd(A_TCSRC, 32'h0);
        wr(A_CH0 + 8'h04, 32'h1);
        wr(A_CH0 + 8'h05, 32'h0);
        wr(A_CH0 + 8'h06, 32'h2);
        wr(A_CH0 + 8'h07, 32'h0);
        wr(A_GRP0 + 8'h01, 32'h33);
        audio_on = 1;
        commit();
        repeat (12000) @(posedge clk_sys_i);
        check(smp_valid_o, 1);
        hold <= 1'b0;
        for (int i = 0; i < 30000 && taken < 8; i++)
            @(posedge clk_sys_i);
        check(taken >= 8, 1);
        wr(A_GRP0 + 8'h01, 32'h32);
        commit();
        repeat (50) @(posedge clk_sys_i);
        audio_on = 0;
        repeat (9000) @(posedge clk_sys_i);
        report_and_stop();
    end
endmodule
bind embedded_audio_timing_gen audio_timing_assertions
    i_audio_timing_assertions (.*);
`default_nettype wire
